// ==== hdl/pin_sync.sv ====
/*
  three flop synchroniser with agreement filter for pin inputs.
  assumes the pin is asynchronous to CLK; output changes when flops two and three agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // chain; first flop feeds only the second
  always_ff @(posedge clk) begin
    s1_r <= d;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  // only accept a level both later flops agree on, masks metastable blips
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ==== hdl/sleep_wake_defines.svh ====
/*
  timing constants, register offset and field positions for the sleep/wake sequencer.
  assumes a 20 mhz core clock and an rtc tick input sampled on that clock.
*/
`ifndef SLEEP_WAKE_DEFINES_SVH
`define SLEEP_WAKE_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define CFG2_OFFSET 8'ha2
`define CFG2_FAIL_BIT 0
`define CFG2_RESET 8'h00
// pci bus reset hold after clocks valid, in us, and in cycles
`define CLK_VALID_HOLD_US 500
`define CLK_VALID_HOLD_CYC ((`CLK_VALID_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// power good to pci bus reset release window, nominal 1.0 ms
`define CORE_POWER_GOOD_REL_MIN_US 900
`define CORE_POWER_GOOD_REL_MAX_US 1100
`define CORE_POWER_GOOD_REL_US 1000
`define CORE_POWER_GOOD_REL_CYC (`CORE_POWER_GOOD_REL_US * 1000 / `CLK_PERIOD_NS)
// pci clock counts
`define CPU_STOP_CLOCK_N_DELAY_PCI 2
`define SLEEP_DELAY_PCI 4
// rtc tick counts
`define RSM_REL_RTC 2
`define SUS_TO_PCI_BUS_RESET_N_RTC 2
`define PCI_BUS_RESET_N_TO_S3_RTC 1
`define S3_TO_S5_RTC 1
`define WAKE_TO_S3_RTC 2
`define S5_TO_S3_RTC 2
`endif

// ==== hdl/sleep_wake_pkg.sv ====
/*
  types of the sleep/wake sequencer.
  assumes the defines header is included by the modules that need counts.
*/
package sleep_wake_pkg;
  typedef enum logic [3:0] {
    ST_STANDBY, ST_RSM_REL, ST_CORE_WAIT, ST_PCI_BUS_RESET_N_HOLD, ST_RUN, ST_SLP_ENTER,
    ST_SUS_WAIT, ST_S3_WAIT, ST_S5_WAIT, ST_SLEEP, ST_WAKE_S5, ST_WAKE_S3
  } seq_state_t;
endpackage

// ==== hdl/sleep_wake_seq.sv ====
/*
  power state sequencer: standby power-up, s0-s3-s0 and s0-s5-s0, reset handshake
  and latched power good failure flag in the general pm config two register.
  assumes rtc and pci tick inputs are pulses on CLK, pins are asynchronous, and the
  config register is reached by an 8-bit indexed port at its printed offset.
*/
// Behaviour
// - standby good drives sleep, pci_bus_reset_n active
// - after resume reset release, deassert outputs
// - cpu sleep inactive after core good
// - pci reset held 500 us after clocks
// - pci reset released about 1 ms after
// - stop clock deasserted 1-4 pci clocks
// - straps valid around pci reset release
// - straps withdrawn after second handshake
// - cpu reset released after second handshake
// - cpu sleep within 8 pci clocks
// - suspend status within one rtc tick
// - pci reset 2-3 rtc after suspend
// - s3 sleep 1-2 rtc after reset
// - s5 sleep 1-2 rtc after s3
// - wake from s3 releases s3 2-3 rtc
// - s5 release then s3 release 2-3 rtc
// - latch power good failure flag bit 0
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"
module sleep_wake_seq
  import sleep_wake_pkg::*;
#(
  parameter int HOLD_CYC = `CLK_VALID_HOLD_CYC,
  parameter int CORE_POWER_GOOD_CYC = `CORE_POWER_GOOD_REL_CYC
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RTC_TICK,
  input wire logic PCI_TICK,
  input wire logic RESUME_WELL_RESET_N,
  input wire logic CORE_POWER_GOOD,
  input wire logic CORE_SUPPLY_GOOD,
  input wire logic CLOCKS_VALID,
  input wire logic HUB_CYCLE1,
  input wire logic HUB_CYCLE2,
  input wire logic STOP_GRANT,
  input wire logic SLEEP_REQ,
  input wire logic SOFT_OFF_REQ,
  input wire logic WAKE_EVENT,
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic REBOOT_ON_RESUME,
  output logic SLEEP_STATE3_N,
  output logic SLEEP_STATE5_N,
  output logic SUSPEND_STATUS_N,
  output logic PCI_BUS_RESET_N,
  output logic CPU_SLEEP_N,
  output logic CPU_STOP_CLOCK_N,
  output logic CPU_RESET_N,
  output logic HANDSHAKE_CYCLE1,
  output logic HANDSHAKE_CYCLE2,
  output logic STRAPS_VALID
);
  localparam int CNT_W = 16;
  localparam int HOLD_W = $clog2(HOLD_CYC + 1) + 1;
  localparam int OK_W = $clog2(CORE_POWER_GOOD_CYC + 1) + 1;

  // pins from other wells except HUB_CYCLE1, synchronised in one bundle
  logic [8:0] pins_raw;
  logic [8:0] pins;
  assign pins_raw = {RESUME_WELL_RESET_N, CORE_POWER_GOOD, CORE_SUPPLY_GOOD, CLOCKS_VALID,
                     HUB_CYCLE2, STOP_GRANT, SLEEP_REQ, SOFT_OFF_REQ, WAKE_EVENT};
  pin_sync #(.W(9)) u_sync (
    .clk(CLK),
    .reset(RESET),
    .d(pins_raw),
    .q(pins)
  );
  logic rsm_n, core_power_good, core_ok, clk_ok, hub2, sgnt, slp_req, off_req, wake;
  assign {rsm_n, core_power_good, core_ok, clk_ok, hub2, sgnt, slp_req, off_req, wake} = pins;

  // tick counting helper for the rtc intervals; the pci stop clock count is tested inline
  function automatic logic tick_done(input logic [CNT_W-1:0] c, input int n, input logic t);
    return t && (c + 16'h0001 >= CNT_W'(n));
  endfunction

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [CNT_W-1:0] tick_r;
  logic [HOLD_W-1:0] hold_r;
  logic [OK_W-1:0] ok_r;
  logic soft_off_r;
  logic hs_phase_r;
  logic [7:0] cfg_r;
  logic core_power_good_d_r;
  logic tick_clr;
  logic tick_en;

  // next state; state machine sequence
  always_comb begin
    state_nxt = state_r;
    tick_en = RTC_TICK;
    case (state_r)
      ST_STANDBY: begin
        if (rsm_n) begin
          state_nxt = ST_RSM_REL;
        end
      end
      ST_RSM_REL: begin
        if (tick_done(tick_r, `RSM_REL_RTC, RTC_TICK)) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      ST_CORE_WAIT: begin
        if (core_power_good && core_ok) begin
          state_nxt = ST_PCI_BUS_RESET_N_HOLD;
        end
      end
      ST_PCI_BUS_RESET_N_HOLD: begin
        if (hold_r >= HOLD_W'(HOLD_CYC) && ok_r >= OK_W'(CORE_POWER_GOOD_CYC)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // stop clock release counts pci ticks
        tick_en = PCI_TICK;
        if (slp_req || off_req) begin
          state_nxt = ST_SLP_ENTER;
        end
      end
      ST_SLP_ENTER: begin
        tick_en = PCI_TICK;
        if (sgnt) begin
          state_nxt = ST_SUS_WAIT;
        end
      end
      ST_SUS_WAIT: begin
        if (tick_done(tick_r, `SUS_TO_PCI_BUS_RESET_N_RTC + 1, RTC_TICK)) begin
          state_nxt = ST_S3_WAIT;
        end
      end
      ST_S3_WAIT: begin
        if (tick_done(tick_r, `PCI_BUS_RESET_N_TO_S3_RTC, RTC_TICK)) begin
          state_nxt = soft_off_r ? ST_S5_WAIT : ST_SLEEP;
        end
      end
      ST_S5_WAIT: begin
        if (tick_done(tick_r, `S3_TO_S5_RTC, RTC_TICK)) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_nxt = soft_off_r ? ST_WAKE_S5 : ST_WAKE_S3;
        end
      end
      ST_WAKE_S5: begin
        if (tick_done(tick_r, `S5_TO_S3_RTC, RTC_TICK)) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      ST_WAKE_S3: begin
        if (tick_done(tick_r, `WAKE_TO_S3_RTC, RTC_TICK)) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      default: begin
        state_nxt = ST_STANDBY;
      end
    endcase
  end
  assign tick_clr = (state_nxt != state_r);

  // state register; loss of resume reset drops back to standby
  always_ff @(posedge CLK) begin
    if (RESET || !rsm_n) begin
      state_r <= ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || tick_clr) begin
      tick_r <= '0;
    end else if (tick_en && tick_r != '1) begin
      tick_r <= tick_r + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || !clk_ok || state_r != ST_PCI_BUS_RESET_N_HOLD) begin
      hold_r <= '0;
    end else if (hold_r < HOLD_W'(HOLD_CYC)) begin
      hold_r <= hold_r + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || !core_power_good || state_r != ST_PCI_BUS_RESET_N_HOLD) begin
      ok_r <= '0;
    end else if (ok_r < OK_W'(CORE_POWER_GOOD_CYC)) begin
      ok_r <= ok_r + 1'b1;
    end
  end

  // soft-off request remembered through sleep
  always_ff @(posedge CLK) begin
    if (RESET) begin
      soft_off_r <= 1'b0;
    end else if (state_r == ST_RUN && state_nxt == ST_SLP_ENTER) begin
      soft_off_r <= off_req;
    end
  end

  // reset and standby force active sleep outputs
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SLEEP_STATE3_N <= 1'b0;
      SLEEP_STATE5_N <= 1'b0;
      PCI_BUS_RESET_N <= 1'b0;
      SUSPEND_STATUS_N <= 1'b0;
    end else begin
      case (state_nxt)
        ST_STANDBY, ST_RSM_REL: begin
          SLEEP_STATE3_N <= 1'b0;
          SLEEP_STATE5_N <= 1'b0;
          SUSPEND_STATUS_N <= 1'b0;
        end
        ST_SLEEP, ST_S5_WAIT: begin
          SLEEP_STATE3_N <= 1'b0;
          SLEEP_STATE5_N <= ~soft_off_r || state_nxt == ST_S5_WAIT;
          SUSPEND_STATUS_N <= 1'b0;
        end
        ST_WAKE_S5, ST_WAKE_S3: begin
          // s3 stays asserted until the wake count runs out
          SLEEP_STATE3_N <= 1'b0;
          SLEEP_STATE5_N <= 1'b1;
          SUSPEND_STATUS_N <= 1'b0;
        end
        ST_S3_WAIT: begin
          SLEEP_STATE3_N <= 1'b1;
          SLEEP_STATE5_N <= 1'b1;
          SUSPEND_STATUS_N <= 1'b0;
        end
        ST_SUS_WAIT: begin
          SLEEP_STATE3_N <= 1'b1;
          SLEEP_STATE5_N <= 1'b1;
          SUSPEND_STATUS_N <= 1'b0;
        end
        default: begin
          SLEEP_STATE3_N <= 1'b1;
          SLEEP_STATE5_N <= 1'b1;
          SUSPEND_STATUS_N <= 1'b1;
        end
      endcase
      // pci reset released only in run, sleep entry and suspend wait
      PCI_BUS_RESET_N <= (state_nxt == ST_RUN || state_nxt == ST_SLP_ENTER ||
                          state_nxt == ST_SUS_WAIT);
    end
  end

  // cpu sleep held through sleep; core supply lags s3 and cannot be trusted there
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CPU_SLEEP_N <= 1'b0;
    end else if (state_nxt inside {ST_SUS_WAIT, ST_S3_WAIT, ST_S5_WAIT, ST_SLEEP,
                                   ST_WAKE_S5, ST_WAKE_S3}) begin
      CPU_SLEEP_N <= 1'b0;
    end else begin
      CPU_SLEEP_N <= core_ok;
    end
  end

  // stop clock released pci ticks after reset release
  always_ff @(posedge CLK) begin
    if (RESET || state_r != ST_RUN && state_r != ST_SLP_ENTER) begin
      CPU_STOP_CLOCK_N <= 1'b0;
    end else if (state_r == ST_SLP_ENTER) begin
      CPU_STOP_CLOCK_N <= 1'b0;
    end else if (PCI_TICK && !CPU_STOP_CLOCK_N && tick_r + 16'h0001 >= 16'(`CPU_STOP_CLOCK_N_DELAY_PCI)) begin
      CPU_STOP_CLOCK_N <= 1'b1;
    end
  end

  // hub handshake: our cycle 1 after hub cycle 1, our cycle 2 after hub cycle 2
  always_ff @(posedge CLK) begin
    if (RESET || state_r != ST_RUN) begin
      hs_phase_r <= 1'b0;
      HANDSHAKE_CYCLE1 <= 1'b0;
      HANDSHAKE_CYCLE2 <= 1'b0;
    end else begin
      HANDSHAKE_CYCLE1 <= HUB_CYCLE1 && !hs_phase_r;
      HANDSHAKE_CYCLE2 <= hub2 && hs_phase_r && !HANDSHAKE_CYCLE2 && CPU_RESET_N == 1'b0;
      if (HUB_CYCLE1) begin
        hs_phase_r <= 1'b1;
      end
    end
  end

  // straps and cpu reset around handshake cycle 2
  always_ff @(posedge CLK) begin
    if (RESET || state_nxt != ST_RUN && state_r != ST_RUN) begin
      STRAPS_VALID <= 1'b0;
      CPU_RESET_N <= 1'b0;
    end else begin
      if (state_r == ST_PCI_BUS_RESET_N_HOLD) begin
        STRAPS_VALID <= 1'b1;
      end else if (HANDSHAKE_CYCLE2) begin
        STRAPS_VALID <= 1'b0;
        CPU_RESET_N <= 1'b1;
      end
    end
  end

  // failure flag: power good drop while powered sets it, set beats write clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      core_power_good_d_r <= 1'b0;
      cfg_r <= `CFG2_RESET;
    end else begin
      core_power_good_d_r <= core_power_good;
      if (CFG_WR && CFG_ADDR == `CFG2_OFFSET) begin
        cfg_r[7:1] <= CFG_WDATA[7:1];
        if (CFG_WDATA[`CFG2_FAIL_BIT]) begin
          cfg_r[`CFG2_FAIL_BIT] <= 1'b0;
        end
      end
      // a drop after s3 is asserted is the requested power-off, not a failure
      if (core_power_good_d_r && !core_power_good && rsm_n && SLEEP_STATE3_N) begin
        cfg_r[`CFG2_FAIL_BIT] <= 1'b1;
      end
    end
  end

  // read port and reboot hint on s3 resume
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CFG_RDATA <= 8'h00;
      REBOOT_ON_RESUME <= 1'b0;
    end else begin
      CFG_RDATA <= (CFG_ADDR == `CFG2_OFFSET) ? cfg_r : 8'h00;
      REBOOT_ON_RESUME <= cfg_r[`CFG2_FAIL_BIT] && !soft_off_r;
    end
  end
endmodule

// ==== verif/platform_sleep_wake_sequencer_bench.sv ====
/* self-checking bench for the sleep/wake sequencer with board model and checker.
   assumes hold counts shortened to 20 and 40 cycles and the model's tick rates. */
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module platform_sleep_wake_sequencer_bench;
  localparam int HOLD = 20;
  localparam int PW = 40;
  logic CLK, RESET, RTC_TICK, PCI_TICK, RESUME_WELL_RESET_N, CORE_POWER_GOOD, CORE_SUPPLY_GOOD;
  logic CLOCKS_VALID, HUB_CYCLE1, HUB_CYCLE2, STOP_GRANT, SLEEP_REQ, SOFT_OFF_REQ, WAKE_EVENT;
  logic CFG_WR, REBOOT_ON_RESUME, SLEEP_STATE3_N, SLEEP_STATE5_N, SUSPEND_STATUS_N;
  logic PCI_BUS_RESET_N, CPU_SLEEP_N, CPU_STOP_CLOCK_N, CPU_RESET_N, HANDSHAKE_CYCLE1;
  logic HANDSHAKE_CYCLE2, STRAPS_VALID, glitch, slow;
  logic [7:0] CFG_ADDR, CFG_WDATA, CFG_RDATA;
  logic [6:0] outs;
  int err_count, total_checks;
  assign outs = {CPU_RESET_N, CPU_STOP_CLOCK_N, CPU_SLEEP_N, PCI_BUS_RESET_N, SUSPEND_STATUS_N,
    SLEEP_STATE5_N, SLEEP_STATE3_N};
  always #25 CLK = ~CLK;
  sleep_wake_seq #(.HOLD_CYC(HOLD), .CORE_POWER_GOOD_CYC(PW)) i_dut (.CLK, .RESET, .RTC_TICK, .PCI_TICK,
    .RESUME_WELL_RESET_N, .CORE_POWER_GOOD, .CORE_SUPPLY_GOOD, .CLOCKS_VALID, .HUB_CYCLE1,
    .HUB_CYCLE2, .STOP_GRANT, .SLEEP_REQ, .SOFT_OFF_REQ, .WAKE_EVENT, .CFG_WR, .CFG_ADDR,
    .CFG_WDATA, .CFG_RDATA, .REBOOT_ON_RESUME, .SLEEP_STATE3_N, .SLEEP_STATE5_N,
    .SUSPEND_STATUS_N, .PCI_BUS_RESET_N, .CPU_SLEEP_N, .CPU_STOP_CLOCK_N, .CPU_RESET_N,
    .HANDSHAKE_CYCLE1, .HANDSHAKE_CYCLE2, .STRAPS_VALID);
  sw_board_model i_board (.clk(CLK), .rst(RESET), .glitch, .slow,
    .req(SLEEP_REQ | SOFT_OFF_REQ), .s3_n(SLEEP_STATE3_N), .pci_n(PCI_BUS_RESET_N),
    .hs1(HANDSHAKE_CYCLE1), .rtc_tick(RTC_TICK), .pci_tick(PCI_TICK),
    .rsm_n(RESUME_WELL_RESET_N), .core_good(CORE_SUPPLY_GOOD), .pwr_good(CORE_POWER_GOOD),
    .clk_valid(CLOCKS_VALID), .hub1(HUB_CYCLE1), .hub2(HUB_CYCLE2), .stop_grant(STOP_GRANT));
  task conclude;
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait on one output, counting cycles
  task automatic wait_out(input int i, input logic v, output int n);
    n = 0;
    while (outs[i] !== v && n < 3000) begin
      @(negedge CLK);
      n++;
    end
    if (n == 3000) begin
      err_count++;
      $display("Error output %0d expected %b seen %b", i, v, outs[i]);
    end
  endtask
  // strobe lowered a cycle early so a following write is a fresh edge
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    CFG_ADDR = a;
    CFG_WDATA = d;
    CFG_WR = 1'b1;
    @(negedge CLK);
    CFG_WR = 1'b0;
    @(negedge CLK);
  endtask
  task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
    CFG_ADDR = a;
    @(negedge CLK);
    d = CFG_RDATA;
  endtask
  task automatic t_powerup;
    logic [7:0] d;
    int n, m;
    cfg_rd(`CFG2_OFFSET, d);
    `CHK("cfg reset", `CFG2_RESET, d)
    `CHK("s3 standby", 1'b0, SLEEP_STATE3_N)
    `CHK("pci_bus_reset_n standby", 1'b0, PCI_BUS_RESET_N)
    wait_out(0, 1'b1, n);
    `CHK("s5 release", 1'b1, SLEEP_STATE5_N)
    `CHK("suspend release", 1'b1, SUSPEND_STATUS_N)
    n = 0;
    m = 0;
    while (PCI_BUS_RESET_N !== 1'b1 && m < 3000) begin
      @(negedge CLK);
      n += CORE_POWER_GOOD;
      m += CLOCKS_VALID;
    end
    `CHK("core_power_good to pci_bus_reset_n", 1'b1, n >= PW * 9 / 10 && n <= PW * 11 / 10 + 4)
    `CHK("clocks to pci_bus_reset_n", 1'b1, m >= HOLD)
    `CHK("straps valid", 1'b1, STRAPS_VALID)
    `CHK("cpu sleep off", 1'b1, CPU_SLEEP_N)
    wait_out(6, 1'b1, n);
    @(negedge CLK);
    `CHK("straps gone", 1'b0, STRAPS_VALID)
    `CHK("stop clock off", 1'b1, CPU_STOP_CLOCK_N)
  endtask
  task automatic t_sleep(input logic off);
    int n;
    SLEEP_REQ = !off;
    SOFT_OFF_REQ = off;
    wait_out(0, 1'b0, n);
    repeat (24) @(negedge CLK);
    SLEEP_REQ = 1'b0;
    SOFT_OFF_REQ = 1'b0;
    `CHK("cpu sleep", 1'b0, CPU_SLEEP_N)
    `CHK("suspend", 1'b0, SUSPEND_STATUS_N)
    `CHK("pci_bus_reset_n", 1'b0, PCI_BUS_RESET_N)
    `CHK("s5 level", !off, SLEEP_STATE5_N)
    WAKE_EVENT = 1'b1;
    wait_out(1, 1'b1, n);
    wait_out(0, 1'b1, n);
    WAKE_EVENT = 1'b0;
    `CHK("s3 release", 1'b1, n >= 9 && n <= 29)
    wait_out(3, 1'b1, n);
    wait_out(6, 1'b1, n);
    `CHK("no reboot", 1'b0, REBOOT_ON_RESUME)
  endtask
  task automatic t_flag;
    logic [7:0] d;
    cfg_wr(`CFG2_OFFSET, 8'hff);
    cfg_wr(8'h10, 8'h00);
    cfg_rd(`CFG2_OFFSET, d);
    `CHK("cfg write", 8'hfe, d)
    cfg_rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    glitch = 1'b1;
    repeat (6) @(negedge CLK);
    glitch = 1'b0;
    repeat (6) @(negedge CLK);
    cfg_rd(`CFG2_OFFSET, d);
    `CHK("fail flag", 8'hff, d)
    `CHK("reboot", 1'b1, REBOOT_ON_RESUME)
  endtask
  // main sequence, then a second reset with a slow hub
  initial begin
    CLK = 1'b0;
    RESET = 1'b1;
    {SLEEP_REQ, SOFT_OFF_REQ, WAKE_EVENT, CFG_WR, glitch, slow} = 6'h00;
    CFG_ADDR = 8'h00;
    CFG_WDATA = 8'h00;
    err_count = 0;
    total_checks = 0;
    repeat (4) @(negedge CLK);
    RESET = 1'b0;
    t_powerup;
    t_sleep(1'b0);
    t_sleep(1'b1);
    RESET = 1'b1;
    slow = 1'b1;
    repeat (4) @(negedge CLK);
    RESET = 1'b0;
    t_powerup;
    t_flag;
    conclude;
  end
  // watchdog: 20000 cycles, many times the under a thousand cycles the run needs
  initial begin
    #1000000;
    err_count++;
    conclude;
  end
endmodule

// ==== verif/sleep_wake_checker.sv ====
/* port assertions for the sleep/wake sequencer.
   assumes rtc ticks every 8 cycles and pci ticks every 2, as the board model makes them. */
`timescale 1ns/1ps
module sleep_wake_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RTC_TICK,
  input wire logic STOP_GRANT,
  input wire logic SLEEP_STATE3_N,
  input wire logic SLEEP_STATE5_N,
  input wire logic SUSPEND_STATUS_N,
  input wire logic PCI_BUS_RESET_N,
  input wire logic CPU_SLEEP_N,
  input wire logic CPU_STOP_CLOCK_N,
  input wire logic CPU_RESET_N,
  input wire logic HANDSHAKE_CYCLE2,
  input wire logic STRAPS_VALID
);
  logic [4:0] outs;
  logic [4:0] prev_r;
  logic [2:0] rtc_r;
  assign outs = {SLEEP_STATE3_N, SLEEP_STATE5_N, SUSPEND_STATUS_N, PCI_BUS_RESET_N, CPU_SLEEP_N};
  // rtc ticks since the last output change; saturates so long idles stay harmless
  always_ff @(posedge CLK) begin
    prev_r <= outs;
    if (RESET || outs != prev_r) begin
      rtc_r <= {2'b00, RTC_TICK};
    end else if (RTC_TICK && rtc_r != 3'h7) begin
      rtc_r <= rtc_r + 3'h1;
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RESET);
  a_reset_outputs_low: assert property ($fell(RESET) |->
    !SLEEP_STATE3_N && !SLEEP_STATE5_N && !PCI_BUS_RESET_N) else $error("outputs not active");
  a_stop_clock_release: assert property ($rose(PCI_BUS_RESET_N) |->
    !CPU_STOP_CLOCK_N ##[2:8] CPU_STOP_CLOCK_N) else $error("stop clock release off");
  a_cpu_reset_release: assert property ($rose(HANDSHAKE_CYCLE2) |->
    ##[0:2] CPU_RESET_N && !STRAPS_VALID) else $error("cpu reset or straps late");
  a_grant_to_sleep: assert property ($rose(STOP_GRANT) && PCI_BUS_RESET_N |->
    ##[1:16] !CPU_SLEEP_N) else $error("cpu sleep late");
  a_sleep_to_suspend: assert property ($fell(SUSPEND_STATUS_N) |->
    !CPU_SLEEP_N && ($fell(CPU_SLEEP_N) || rtc_r <= 3'h1)) else $error("suspend late");
  a_suspend_to_pci_bus_reset_n: assert property ($fell(PCI_BUS_RESET_N) && !SUSPEND_STATUS_N |->
    rtc_r >= 3'h2 && rtc_r <= 3'h3) else $error("pci reset timing");
  a_pci_bus_reset_n_to_s3: assert property ($fell(SLEEP_STATE3_N) |->
    !PCI_BUS_RESET_N && rtc_r >= 3'h1 && rtc_r <= 3'h2) else $error("s3 timing");
  a_s3_to_s5: assert property ($fell(SLEEP_STATE5_N) |->
    !SLEEP_STATE3_N && rtc_r >= 3'h1 && rtc_r <= 3'h2) else $error("s5 timing");
  a_straps_at_release: assert property ($rose(PCI_BUS_RESET_N) |->
    STRAPS_VALID) else $error("straps not valid at pci reset release");
endmodule
bind sleep_wake_seq sleep_wake_checker i_chk (.CLK, .RESET, .RTC_TICK, .STOP_GRANT,
  .SLEEP_STATE3_N, .SLEEP_STATE5_N, .SUSPEND_STATUS_N, .PCI_BUS_RESET_N, .CPU_SLEEP_N,
  .CPU_STOP_CLOCK_N, .CPU_RESET_N, .HANDSHAKE_CYCLE2, .STRAPS_VALID);

// ==== verif/sw_board_model.sv ====
/* board supplies, processor and memory hub around the sequencer.
   assumes delays scaled down to cycles; standby supply is good from time zero. */
`timescale 1ns/1ps
module sw_board_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic glitch,
  input wire logic slow,
  input wire logic req,
  input wire logic s3_n,
  input wire logic pci_n,
  input wire logic hs1,
  output logic rtc_tick,
  output logic pci_tick,
  output logic rsm_n,
  output logic core_good,
  output logic pwr_good,
  output logic clk_valid,
  output logic hub1,
  output logic hub2,
  output logic stop_grant
);
  logic [7:0] cnt_r;
  logic [7:0] on_r;
  logic [7:0] up_r;
  logic [1:0] s3d_r;
  // tick sources run free from cnt_r; core supply follows the s3 output
  assign rtc_tick = cnt_r[2:0] == 3'h7;
  assign pci_tick = cnt_r[0];
  assign core_good = on_r >= 8'h02;
  assign clk_valid = on_r >= 8'h06;
  // drops a cycle after s3 or reset, ahead of core; glitch on command
  assign pwr_good = s3d_r[0] && on_r >= 8'h0c && !glitch;
  // first hub cycle, prompt or slow
  assign hub1 = up_r == (slow ? 8'hc8 : 8'h14);
  always_ff @(posedge clk) begin
    cnt_r <= rst ? 8'h00 : cnt_r + 8'h01;
    s3d_r <= {s3d_r[0], s3_n};
    on_r <= !s3d_r[1] ? 8'h00 : on_r + {7'h00, on_r != 8'hff};
    up_r <= (rst || !pci_n) ? 8'h00 : up_r + {7'h00, up_r != 8'hff};
    // resume reset held well after standby good
    rsm_n <= !rst && (rsm_n || cnt_r == 8'h1e);
    // second hub cycle on the next edge
    hub2 <= !rst && pci_n && (hub2 || hs1);
    stop_grant <= !rst && pci_n && (stop_grant || req);
  end
endmodule
